// file: design/ptw_pkg.sv
`default_nettype none
package ptw_pkg;
  // ---------------------------------------------------------------------------
  // Register map (word indices; byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TICK_CONTROL_IDX = 8'h14;
  localparam logic [7:0] TICK_FLAG_IDX = 8'h15;
  localparam logic [7:0] SUPERVISOR_CONTROL_IDX = 8'h16;
  localparam logic [7:0] WATCHDOG_SERVICE_IDX = 8'h17;
  localparam logic [7:0] MODE_CONTROL_IDX = 8'h18;
  localparam logic [7:0] STATUS_IDX = 8'h19;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int TICK_IRQ_ENABLE_POS = 7;
  localparam int HALT_IN_WAIT_POS = 6;
  localparam int HALT_IN_DEBUG_POS = 5;
  localparam int TICK_DIVIDER_BYPASS_POS = 3;
  localparam int TICK_FLAG_BIT_POS = 7;
  localparam int CLKMON_ENABLE_POS = 7;
  localparam int CLKMON_FORCE_ENABLE_POS = 6;
  localparam int CLKMON_FORCE_RESET_POS = 5;
  localparam int WATCHDOG_FORCE_RESET_POS = 4;
  localparam int RESET_SUPPRESS_POS = 3;
  // Write masks for the two control registers
  localparam logic [7:0] TICK_CTRL_MASK = 8'hEF;
  localparam logic [7:0] SUP_CTRL_MASK = 8'hFF;
  // ---------------------------------------------------------------------------
  // Service values and timing
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SERVICE_FIRST = 8'h55;
  localparam logic [7:0] SERVICE_SECOND = 8'hAA;
  localparam int PRESCALE_LOG2 = 13;
  localparam int BYPASS_LOG2 = 2;
  localparam int CLK_MHZ = 250;
  localparam int CLKMON_WINDOW_NS = 2000;
  localparam int CLKMON_CYCLES = (CLKMON_WINDOW_NS * CLK_MHZ) / 1000;
  localparam int CLKMON_CNT_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  // Watchdog service sequence states (Gray along the path)
  typedef enum logic [1:0] {
    PTW_SVC_IDLE = 2'b00,
    PTW_SVC_ARMED = 2'b01
  } ptw_svc_t;
endpackage
`default_nettype wire

// file: design/ptw_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Tick rate field selects divide 2^13..2^19
// - Tick flag sets each elapsed period
// - Tick request when flag and enable
// - Writing one to flag clears it
// - Halt-in-wait stops tick and watchdog
// - Halt-in-debug stops tick and watchdog
// - Bypass makes tick divider divide by four
// - Lost clock within window forces reset
// - Monitor enable bit arms clock-loss reset
// - Force enable keeps monitor on until reset
// - Force clock-monitor reset bit adds nothing beyond a monitor fault
// - Force watchdog reset bit adds nothing beyond a watchdog timeout
// - Suppress bit blocks monitor and watchdog resets
// - Watchdog rate field selects timeout divisors
// - Any other service value resets
// - Service register always reads zero
// - Unserviced enabled watchdog resets system
module ptw_watchdog (
  input wire logic hclk, // Module clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Always ready
  output logic [1:0] hresp, // Always OKAY
  input wire logic special_mode, // Special (test) mode
  input wire logic wait_mode, // CPU in wait mode
  input wire logic debug_mode, // Background debug active
  input wire logic clock_edge_seen, // Activity from delay monitor
  output logic tick_irq, // Periodic tick request
  output logic system_reset_req // Watchdog/monitor reset
);
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] tick_control_reg;
  logic [7:0] tick_flag_reg;
  logic [7:0] supervisor_control_reg;
  logic [1:0] tick_once_reg;
  logic [1:0] sup_once_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_idx_reg;
  logic [22:0] prescale_reg;
  logic [22:0] tick_prev_reg;
  localparam int CLKMON_W = ptw_pkg::CLKMON_CNT_W;
  logic [10:0] wd_count_reg;
  logic [CLKMON_W-1:0] clkmon_count_reg;
  ptw_pkg::ptw_svc_t svc_state_reg;

  logic halted;
  logic wr_en;
  logic wr_tick_ctl;
  logic wr_tick_flag;
  logic wr_sup_ctl;
  logic wr_service;
  logic svc_complete;
  logic [7:0] wdat;
  logic tick_edge;
  logic wd_tick;
  logic wd_timeout;
  logic bad_service;
  logic clkmon_on;
  logic clkmon_fault;
  logic [2:0] tick_rate_sel;
  logic [2:0] watchdog_rate_sel;

  // Word-index decode of a byte address
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction

  // Tap of the free prescaler feeding one chain output
  function automatic logic tap(input logic [22:0] p, input int b);
    tap = p[b];
  endfunction

  assign tick_rate_sel = tick_control_reg[2:0];
  assign watchdog_rate_sel = supervisor_control_reg[2:0];
  assign wdat = hwdata[7:0];
  assign wr_en = ap_valid_reg && ap_write_reg;

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  // Per-register write strobes, valid in the data phase
  assign wr_tick_ctl = wr_en && ap_idx_reg == ptw_pkg::TICK_CONTROL_IDX;
  assign wr_tick_flag = wr_en && ap_idx_reg == ptw_pkg::TICK_FLAG_IDX;
  assign wr_sup_ctl = wr_en
    && ap_idx_reg == ptw_pkg::SUPERVISOR_CONTROL_IDX;
  assign wr_service = wr_en
    && ap_idx_reg == ptw_pkg::WATCHDOG_SERVICE_IDX;
  assign svc_complete = wr_service
    && svc_state_reg == ptw_pkg::PTW_SVC_ARMED
    && wdat == ptw_pkg::SERVICE_SECOND;

  // Either halt condition freezes the shared prescaler, so the tick
  // and the watchdog always pause and resume together
  assign halted = (tick_control_reg[ptw_pkg::HALT_IN_WAIT_POS] && wait_mode)
    || (tick_control_reg[ptw_pkg::HALT_IN_DEBUG_POS] && debug_mode);

  // ---------------------------------------------------------------------------
  // AHB-Lite slave: address phase capture, zero-wait data phase
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_idx_reg <= 8'h00;
    end else if (hready) begin
      ap_valid_reg <= hsel && htrans[1];
      ap_write_reg <= hwrite;
      ap_idx_reg <= idx_of(haddr);
    end
  end

  // Read data register, loaded at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (idx_of(haddr))
        ptw_pkg::TICK_CONTROL_IDX: hrdata <= {24'h000000, tick_control_reg};
        ptw_pkg::TICK_FLAG_IDX: hrdata <= {24'h000000, tick_flag_reg};
        ptw_pkg::SUPERVISOR_CONTROL_IDX:
          hrdata <= {24'h000000, supervisor_control_reg};
        ptw_pkg::WATCHDOG_SERVICE_IDX: hrdata <= 32'h0000_0000;
        ptw_pkg::STATUS_IDX:
          hrdata <= {29'h0, clkmon_on, halted, svc_state_reg[0]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Bus answers are always ready and OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= ptw_pkg::RESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= ptw_pkg::RESP_OKAY;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers with write-once / special-only access
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_control_reg <= ptw_pkg::REG_RESET;
      tick_once_reg <= 2'b00;
    end else if (wr_tick_ctl) begin
      tick_control_reg[ptw_pkg::TICK_IRQ_ENABLE_POS] <=
        wdat[ptw_pkg::TICK_IRQ_ENABLE_POS];
      tick_control_reg[2:0] <= wdat[2:0];
      if (special_mode || !tick_once_reg[0]) begin
        tick_control_reg[ptw_pkg::HALT_IN_WAIT_POS] <=
          wdat[ptw_pkg::HALT_IN_WAIT_POS];
        tick_once_reg[0] <= 1'b1;
      end
      if (special_mode || !tick_once_reg[1]) begin
        tick_control_reg[ptw_pkg::HALT_IN_DEBUG_POS] <=
          wdat[ptw_pkg::HALT_IN_DEBUG_POS];
        tick_once_reg[1] <= 1'b1;
      end
      if (special_mode) begin
        tick_control_reg[ptw_pkg::TICK_DIVIDER_BYPASS_POS] <=
          wdat[ptw_pkg::TICK_DIVIDER_BYPASS_POS];
      end
    end
  end

  // Supervisor control: enable anytime, the rest once or special-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supervisor_control_reg <= ptw_pkg::REG_RESET;
      sup_once_reg <= 2'b00;
    end else if (wr_sup_ctl) begin
      supervisor_control_reg[ptw_pkg::CLKMON_ENABLE_POS] <=
        wdat[ptw_pkg::CLKMON_ENABLE_POS];
      if (special_mode || !sup_once_reg[0]) begin
        supervisor_control_reg[ptw_pkg::CLKMON_FORCE_ENABLE_POS] <=
          wdat[ptw_pkg::CLKMON_FORCE_ENABLE_POS];
        sup_once_reg[0] <= 1'b1;
      end
      if (special_mode) begin
        supervisor_control_reg[ptw_pkg::CLKMON_FORCE_RESET_POS] <=
          wdat[ptw_pkg::CLKMON_FORCE_RESET_POS];
        supervisor_control_reg[ptw_pkg::WATCHDOG_FORCE_RESET_POS] <=
          wdat[ptw_pkg::WATCHDOG_FORCE_RESET_POS];
        supervisor_control_reg[ptw_pkg::RESET_SUPPRESS_POS] <=
          wdat[ptw_pkg::RESET_SUPPRESS_POS];
      end
      if (special_mode || !sup_once_reg[1]) begin
        supervisor_control_reg[2:0] <= wdat[2:0];
        sup_once_reg[1] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Free-running prescaler (M-clock divider chain)
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_reg <= 23'h000000;
      tick_prev_reg <= 23'h000000;
    end else if (!halted) begin
      prescale_reg <= prescale_reg + 23'h000001;
      tick_prev_reg <= prescale_reg;
    end
  end

  // Tick chain tap: bit 11+rate, or bit 1+rate-1 when bypassed
  always_comb begin
    int b;
    b = 0;
    if (tick_control_reg[ptw_pkg::TICK_DIVIDER_BYPASS_POS]) begin
      b = ptw_pkg::BYPASS_LOG2 - 1 + int'(tick_rate_sel) - 1;
    end else begin
      b = ptw_pkg::PRESCALE_LOG2 - 1 + int'(tick_rate_sel) - 1;
    end
    tick_edge = (tick_rate_sel != 3'b000) && !halted
      && tap(tick_prev_reg, b) && !tap(prescale_reg, b);
  end

  // Tick flag: set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_flag_reg <= ptw_pkg::REG_RESET;
    end else if (tick_edge) begin
      tick_flag_reg[ptw_pkg::TICK_FLAG_BIT_POS] <= 1'b1;
    end else if (wr_tick_flag && wdat[ptw_pkg::TICK_FLAG_BIT_POS]) begin
      tick_flag_reg[ptw_pkg::TICK_FLAG_BIT_POS] <= 1'b0;
    end
  end

  // Tick request output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_irq <= 1'b0;
    end else begin
      tick_irq <= tick_flag_reg[ptw_pkg::TICK_FLAG_BIT_POS]
        && tick_control_reg[ptw_pkg::TICK_IRQ_ENABLE_POS];
    end
  end

  // ---------------------------------------------------------------------------
  // Watchdog: counts M/2^13 periods after the prescaler
  // ---------------------------------------------------------------------------
  assign wd_tick = !halted
    && tick_prev_reg[ptw_pkg::PRESCALE_LOG2-1]
    && !prescale_reg[ptw_pkg::PRESCALE_LOG2-1];

  // Watchdog ticks of M/2^13 that make up each selected timeout
  function automatic logic [10:0] wd_limit(input logic [2:0] r);
    case (r)
      3'b001: wd_limit = 11'h001;
      3'b010: wd_limit = 11'h004;
      3'b011: wd_limit = 11'h010;
      3'b100: wd_limit = 11'h040;
      3'b101: wd_limit = 11'h100;
      3'b110: wd_limit = 11'h200;
      3'b111: wd_limit = 11'h400;
      default: wd_limit = 11'h000;
    endcase
  endfunction

  // Timeout on the tick after the count reaches its limit; the free
  // prescaler can stretch a period by up to one tick, never shorten it
  assign wd_timeout = (watchdog_rate_sel != 3'b000) && wd_tick
    && (wd_count_reg >= wd_limit(watchdog_rate_sel));

  assign bad_service = wr_service
    && wdat != ptw_pkg::SERVICE_FIRST
    && wdat != ptw_pkg::SERVICE_SECOND;

  // Service sequence: first value arms, second value completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_state_reg <= ptw_pkg::PTW_SVC_IDLE;
    end else if (wr_service) begin
      case (svc_state_reg)
        ptw_pkg::PTW_SVC_IDLE: begin
          if (wdat == ptw_pkg::SERVICE_FIRST) begin
            svc_state_reg <= ptw_pkg::PTW_SVC_ARMED;
          end
        end
        ptw_pkg::PTW_SVC_ARMED: begin
          if (wdat == ptw_pkg::SERVICE_SECOND) begin
            svc_state_reg <= ptw_pkg::PTW_SVC_IDLE;
          end
        end
        default: begin
          svc_state_reg <= ptw_pkg::PTW_SVC_IDLE;
        end
      endcase
    end
  end

  // Watchdog tick counter, cleared by a completed service or a timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_count_reg <= 11'h000;
    end else if (svc_complete) begin
      wd_count_reg <= 11'h000;
    end else if (wd_timeout) begin
      wd_count_reg <= 11'h000;
    end else if (wd_tick && watchdog_rate_sel != 3'b000) begin
      wd_count_reg <= wd_count_reg + 11'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock-loss monitor: window of no activity from the delay element
  // ---------------------------------------------------------------------------
  assign clkmon_on = supervisor_control_reg[ptw_pkg::CLKMON_FORCE_ENABLE_POS]
    || supervisor_control_reg[ptw_pkg::CLKMON_ENABLE_POS];
  assign clkmon_fault = clkmon_on
    && clkmon_count_reg >= CLKMON_W'(ptw_pkg::CLKMON_CYCLES);

  // Cycles without activity; saturates once the window is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkmon_count_reg <= '0;
    end else if (!clkmon_on || clock_edge_seen) begin
      clkmon_count_reg <= '0;
    end else if (!clkmon_fault) begin
      clkmon_count_reg <= clkmon_count_reg + CLKMON_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Reset request, gated by the suppress bit
  // ---------------------------------------------------------------------------
  // Sticky until hresetn or the suppress bit, so an unsuppressed one-cycle fault is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_reset_req <= 1'b0;
    end else if (supervisor_control_reg[ptw_pkg::RESET_SUPPRESS_POS]) begin
      system_reset_req <= 1'b0;
    end else if (clkmon_fault
        || (supervisor_control_reg[ptw_pkg::CLKMON_FORCE_RESET_POS]
            && clkmon_fault)) begin
      system_reset_req <= 1'b1;
    end else if (wd_timeout || bad_service
        || (supervisor_control_reg[ptw_pkg::WATCHDOG_FORCE_RESET_POS]
            && wd_timeout)) begin
      system_reset_req <= 1'b1;
    end
  end
endmodule // ptw_watchdog
`default_nettype wire

// file: tb/ptw_watchdog_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_chk (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic [1:0] hresp, // Response
  input wire logic special_mode, // Special
  input wire logic wait_mode, // Wait
  input wire logic debug_mode, // Debug
  input wire logic clock_edge_seen, // Activity
  input wire logic tick_irq, // Tick request
  input wire logic system_reset_req // Reset request
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // Bus phase tracking and register shadows
  // ---------------------------------------------------------------
  logic v_q, w_q, en_q, cme_q, sup_q;
  logic [7:0] a_q;
  logic [9:0] lo_cnt;
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      v_q <= hsel && hready && htrans[1];
      w_q <= hwrite;
      a_q <= haddr[9:2];
    end
  end
  // Shadows of the enables and suppress bit written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
      cme_q <= 1'b0;
      sup_q <= 1'b0;
    end else if (v_q && w_q) begin
      if (a_q == ptw_pkg::TICK_CONTROL_IDX) en_q <= hwdata[7];
      if (a_q == ptw_pkg::SUPERVISOR_CONTROL_IDX) begin
        cme_q <= hwdata[7];
        if (special_mode) sup_q <= hwdata[3];
      end
    end
  end
  // Consecutive cycles without clock activity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lo_cnt <= 10'h000;
    else if (clock_edge_seen) lo_cnt <= 10'h000;
    else if (lo_cnt != 10'h3FF) lo_cnt <= lo_cnt + 10'h001;
  end
  AST_READY: assert property (hreadyout == 1'b1)
    else $error("ready dropped");
  AST_RESP: assert property (hresp == ptw_pkg::RESP_OKAY)
    else $error("response not okay");
  AST_UPPER: assert property (v_q && !w_q |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_SVC_ZERO: assert property (v_q && !w_q &&
    a_q == ptw_pkg::WATCHDOG_SERVICE_IDX |-> hrdata == 32'h00000000)
    else $error("service read not zero");
  AST_UNMAPPED: assert property (v_q && !w_q && a_q == 8'h30
    |-> hrdata == 32'h00000000) else $error("unmapped read not zero");
  AST_IRQ_EN: assert property (!en_q [*3] |-> !tick_irq)
    else $error("tick request without enable");
  AST_BAD_SVC: assert property (v_q && w_q && !sup_q &&
    a_q == ptw_pkg::WATCHDOG_SERVICE_IDX &&
    hwdata[7:0] != ptw_pkg::SERVICE_FIRST &&
    hwdata[7:0] != ptw_pkg::SERVICE_SECOND |-> ##[1:4] system_reset_req)
    else $error("bad service value without reset");
  AST_STICKY: assert property (system_reset_req |=> system_reset_req)
    else $error("reset request dropped");
  AST_CLKMON: assert property (cme_q && !sup_q &&
    lo_cnt == 10'h208 |-> ##[0:8] system_reset_req)
    else $error("lost clock without reset");
  AST_SUPPRESS: assert property (sup_q [*2] |->
    !$rose(system_reset_req)) else $error("reset while suppressed");
endmodule // ptw_chk
bind ptw_watchdog ptw_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .special_mode(special_mode),
  .wait_mode(wait_mode), .debug_mode(debug_mode),
  .clock_edge_seen(clock_edge_seen), .tick_irq(tick_irq),
  .system_reset_req(system_reset_req));
`default_nettype wire

// file: tb/test_periodic_tick_watchdog_clkmon.sv
`timescale 1ns/1ps
`default_nettype none
module test_periodic_tick_watchdog_clkmon;
  logic hclk, hresetn, hsel, hwrite, sp, wm, dm, ces;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic hready, irq, req;
  int bad_count, comparisons, cyc;
  localparam logic [7:0] TC = ptw_pkg::TICK_CONTROL_IDX;
  localparam logic [7:0] TF = ptw_pkg::TICK_FLAG_IDX;
  localparam logic [7:0] SC = ptw_pkg::SUPERVISOR_CONTROL_IDX;
  localparam logic [7:0] SV = ptw_pkg::WATCHDOG_SERVICE_IDX;
  ptw_watchdog dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .special_mode(sp),
    .wait_mode(wm), .debug_mode(dm), .clock_edge_seen(ces),
    .tick_irq(irq), .system_reset_req(req));
  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 8'h00);
    check(q, exp);
  endtask
  task automatic rst(input logic mode);
    hresetn <= 1'b0;
    sp <= mode;
    wm <= 1'b0;
    dm <= 1'b0;
    ces <= 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ids [5];
    ids = '{TC, TF, SC, SV, 8'h30};
    foreach (ids[i]) rd(ids[i], 32'h00000000);
  endtask
  task automatic t_tick();
    bus(TC, 1'b1, 8'h09);
    rd(TC, 32'h00000001);
    repeat (100) @(posedge hclk);
    rd(TF, 32'h00000000);
    rst(1'b1);
    bus(TC, 1'b1, 8'h09);
    repeat (100) @(posedge hclk);
    rd(TF, 32'h00000080);
    check(irq, 1'b0);
    bus(TC, 1'b1, 8'h80);
    repeat (4) @(posedge hclk);
    check(irq, 1'b1);
    bus(TF, 1'b1, 8'h80);
    repeat (100) @(posedge hclk);
    rd(TF, 32'h00000000);
    check(irq, 1'b0);
  endtask
  task automatic t_halt(input logic [7:0] ctl, input logic w,
                        input logic d);
    wm <= w;
    dm <= d;
    bus(TC, 1'b1, ctl);
    bus(TF, 1'b1, 8'h80);
    repeat (100) @(posedge hclk);
    rd(TF, 32'h00000000);
    wm <= 1'b0;
    dm <= 1'b0;
    repeat (100) @(posedge hclk);
    rd(TF, 32'h00000080);
  endtask
  task automatic t_svc();
    rst(1'b0);
    bus(SV, 1'b1, ptw_pkg::SERVICE_FIRST);
    rd(SV, 32'h00000000);
    bus(SV, 1'b1, 8'h12);
    repeat (4) @(posedge hclk);
    check(req, 1'b1);
    rst(1'b1);
    bus(SC, 1'b1, 8'h88);
    bus(SV, 1'b1, 8'h12);
    ces <= 1'b0;
    repeat (700) @(posedge hclk);
    check(req, 1'b0);
  endtask
  task automatic t_clkmon(input logic [7:0] ctl, input logic exp);
    rst(1'b0);
    bus(SC, 1'b1, ctl);
    ces <= 1'b0;
    repeat (400) @(posedge hclk);
    check(req, 1'b0);
    repeat (200) @(posedge hclk);
    check(req, exp);
  endtask
  task automatic t_wdog();
    int n;
    rst(1'b0);
    bus(SC, 1'b1, 8'h01);
    bus(SC, 1'b1, 8'h00);
    rd(SC, 32'h00000001);
    repeat (8000) @(posedge hclk);
    check(req, 1'b0);
    n = 0;
    while (req !== 1'b1 && n < 9000) begin
      @(posedge hclk);
      n++;
    end
    check(req, 1'b1);
    rst(1'b0);
    bus(SC, 1'b1, 8'h01);
    repeat (4) begin
      repeat (6000) @(posedge hclk);
      bus(SV, 1'b1, ptw_pkg::SERVICE_FIRST);
      bus(TF, 1'b0, 8'h00);
      bus(SV, 1'b1, ptw_pkg::SERVICE_SECOND);
    end
    check(req, 1'b0);
  endtask
  initial begin
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    rst(1'b0);
    t_regs();
    t_tick();
    t_halt(8'h49, 1'b1, 1'b0);
    t_halt(8'h29, 1'b0, 1'b1);
    t_svc();
    t_clkmon(8'h80, 1'b1);
    t_clkmon(8'h00, 1'b0);
    t_wdog();
    wrap_up();
  end
endmodule // test_periodic_tick_watchdog_clkmon
`default_nettype wire
